// *** verilog/bnvm_defines.svh ***
/*
 Timing and width constants for the bytewide memory controller.
 Assumes a 125 MHz controller clock; included by bare name.
*/
`ifndef BNVM_DEFINES_SVH
`define BNVM_DEFINES_SVH
// ==========================================================
// Clock and device timing
`define BNVM_CLK_PERIOD_NS 8
`define BNVM_SELECT_LOW_MIN_NS 70
`define BNVM_SELECT_LOW_MAX_NS 2000
`define BNVM_RECOVERY_HIGH_MIN_NS 60
`define BNVM_SELECT_TO_VALID_NS 70
`define BNVM_GATE_TO_VALID_NS 10
`define BNVM_WRITE_PULSE_MIN_NS 40
`define BNVM_DATA_HOLD_NS 5
// Minimums round up, maximums round down
`define BNVM_CEIL_CYC(ns) (((ns) + `BNVM_CLK_PERIOD_NS - 1) / `BNVM_CLK_PERIOD_NS)
`define BNVM_FLOOR_CYC(ns) ((ns) / `BNVM_CLK_PERIOD_NS)
// ==========================================================
// Widths
`define BNVM_ADDR_W 15
`define BNVM_DATA_W 8
`endif

// *** verilog/bnvm_pkg.sv ***
/*
 Types shared by the bytewide memory controller.
 Assumes bnvm_defines.svh is on the include path.
*/
`include "bnvm_defines.svh"
package bnvm_pkg;
   // ==========================================================
   // Request and pin bundles, sequencer states
   typedef struct packed {
      logic write;
      logic [`BNVM_ADDR_W-1:0] addr;
      logic [`BNVM_DATA_W-1:0] wdata;
   } bnvm_req_t;

   typedef struct packed {
      logic select_n;
      logic gate_n;
      logic wstrobe_n;
      logic [`BNVM_ADDR_W-1:0] location_lines;
   } bnvm_pins_t;

   typedef enum logic [2:0] {
      BNVM_IDLE,
      BNVM_ACCESS,
      BNVM_RECOVER
   } bnvm_state_t;
endpackage : bnvm_pkg

// *** verilog/bnvm_sync.sv ***
/*
 Two-flop synchroniser for a bus of pin inputs.
 Assumes the inputs are asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module bnvm_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   // ==========================================================
   // Stage one feeds stage two only
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end
   assign q_o = sync_r;
endmodule : bnvm_sync
`default_nettype wire

// *** verilog/bnvm_ctrl.sv ***
/*
 Clocked controller driving a bytewide nonvolatile memory by its pins.
 Assumes the memory pins are wired to the outputs; the byte lines are
 resolved outside from out, output enable (low = driving) and input.
*/
// Overview of operation
// - Every access gets its own fresh select falling edge.
// - Select stays high at least 60 ns between accesses.
// - Select low lasts at least 70 ns and at most 2000 ns.
// - Controller suppresses accesses while supply is out of tolerance.
// - Write strobe low at select fall makes a select-controlled write.
`timescale 1ns/100ps
`default_nettype none
`include "bnvm_defines.svh"
module bnvm_ctrl #(
   parameter int LOW_CYC = `BNVM_CEIL_CYC(`BNVM_SELECT_LOW_MIN_NS),
   parameter int HIGH_CYC = `BNVM_CEIL_CYC(`BNVM_RECOVERY_HIGH_MIN_NS),
   parameter int VALID_CYC = `BNVM_CEIL_CYC(`BNVM_SELECT_TO_VALID_NS)
      + `BNVM_CEIL_CYC(`BNVM_GATE_TO_VALID_NS)
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic supply_ok_i,
   input wire logic req_valid_i,
   input wire bnvm_pkg::bnvm_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [`BNVM_DATA_W-1:0] rsp_data_o,
   output bnvm_pkg::bnvm_pins_t pins_o,
   input wire logic [`BNVM_DATA_W-1:0] byte_lines_i,
   output logic [`BNVM_DATA_W-1:0] byte_lines_o,
   output logic byte_lines_oe_n_o
);
   localparam int CNT_W = 8;
   localparam int MAX_CYC = `BNVM_FLOOR_CYC(`BNVM_SELECT_LOW_MAX_NS);
   // Reads hold select until data is sampled; still far below the maximum
   localparam int RD_CYC = (VALID_CYC + 2 > LOW_CYC) ? VALID_CYC + 2 : LOW_CYC;
   localparam int ACC_CYC = (RD_CYC < MAX_CYC) ? RD_CYC : MAX_CYC;

   bnvm_pkg::bnvm_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic write_r;
   logic [`BNVM_DATA_W-1:0] rd_sync;
   logic supply_ok_sync;

   // ==========================================================
   // Pin input synchronisation
   bnvm_sync #(.W(`BNVM_DATA_W + 1)) u_sync (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .d_i({supply_ok_i, byte_lines_i}),
      .q_o({supply_ok_sync, rd_sync})
   );

   // ==========================================================
   // Decode of the sequencer's turning points
   logic take;
   logic acc_end;
   logic rec_end;

   // Take only on an edge where ready was already shown high
   always_comb begin
      take = 1'b0;
      if (state_r == bnvm_pkg::BNVM_IDLE) begin
         take = req_valid_i && req_ready_o && supply_ok_sync;
      end
   end

   always_comb begin
      acc_end = 1'b0;
      if (state_r == bnvm_pkg::BNVM_ACCESS) begin
         acc_end = (cnt_r <= CNT_W'(1));
      end
   end

   always_comb begin
      rec_end = 1'b0;
      if (state_r == bnvm_pkg::BNVM_RECOVER) begin
         rec_end = (cnt_r <= CNT_W'(1));
      end
   end

   // ==========================================================
   // Access sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= bnvm_pkg::BNVM_IDLE;
      end else if (ce_i) begin
         case (state_r)
            bnvm_pkg::BNVM_IDLE: begin
               if (take) begin
                  state_r <= bnvm_pkg::BNVM_ACCESS;
               end
            end
            bnvm_pkg::BNVM_ACCESS: begin
               if (acc_end) begin
                  state_r <= bnvm_pkg::BNVM_RECOVER;
               end
            end
            bnvm_pkg::BNVM_RECOVER: begin
               if (rec_end) begin
                  state_r <= bnvm_pkg::BNVM_IDLE;
               end
            end
            default: begin
               state_r <= bnvm_pkg::BNVM_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Interval counter
   // One counter serves both phases; it is reloaded as each phase begins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_r <= '0;
      end else if (ce_i) begin
         if (take) begin
            cnt_r <= CNT_W'(req_i.write ? LOW_CYC : ACC_CYC);
         end else if (acc_end) begin
            cnt_r <= CNT_W'(HIGH_CYC);
         end else if (cnt_r > CNT_W'(1)) begin
            cnt_r <= cnt_r - CNT_W'(1);
         end
      end
   end

   // ==========================================================
   // Request acceptance
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         req_ready_o <= 1'b0;
      end else if (ce_i) begin
         if (take) begin
            req_ready_o <= 1'b0;
         end else if (state_r == bnvm_pkg::BNVM_IDLE) begin
            req_ready_o <= supply_ok_sync;
         end
      end
   end

   // Direction kept for the response at the end of the access
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         write_r <= 1'b0;
      end else if (ce_i) begin
         if (take) begin
            write_r <= req_i.write;
         end
      end
   end

   // ==========================================================
   // Memory strobes and location
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pins_o.select_n <= 1'b1;
         pins_o.gate_n <= 1'b1;
         pins_o.wstrobe_n <= 1'b1;
         pins_o.location_lines <= '0;
      end else if (ce_i) begin
         if (take) begin
            pins_o.select_n <= 1'b0;
            pins_o.location_lines <= req_i.addr;
            pins_o.wstrobe_n <= ~req_i.write;
            pins_o.gate_n <= req_i.write;
         end else if (acc_end) begin
            pins_o.select_n <= 1'b1;
            pins_o.wstrobe_n <= 1'b1;
            pins_o.gate_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Byte line driver
   // Enable drops one cycle after the strobes rise, so write data
   // outlasts the end of the array write by a full clock period
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         byte_lines_o <= '0;
         byte_lines_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         if (take) begin
            byte_lines_o <= req_i.wdata;
            byte_lines_oe_n_o <= ~req_i.write;
         end else if (state_r == bnvm_pkg::BNVM_RECOVER) begin
            byte_lines_oe_n_o <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Response
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o <= '0;
      end else if (ce_i) begin
         rsp_valid_o <= acc_end;
         if (acc_end && !write_r) begin
            rsp_data_o <= rd_sync;
         end
      end
   end
endmodule : bnvm_ctrl
`default_nettype wire

// *** bench/bnvm_mem_model.sv ***
/* Behavioural memory seen from the controller pins.
 Assumes the bench resolves the byte lines. */
`timescale 1ns/100ps
`default_nettype none
module bnvm_mem_model (
   input wire bnvm_pkg::bnvm_pins_t pins_i,
   input wire logic [7:0] bus_i,
   output logic [7:0] q_o
);
   logic [7:0] mem [0:32767];
   logic [14:0] a = '0;
   logic [7:0] lst = 8'hA5;
   logic w = 1'b0;
   logic done = 1'b0;
   // ====
   // latch, never refuse
   always @(negedge pins_i.select_n) begin
      a = pins_i.location_lines;
      w = !pins_i.wstrobe_n;
      done = 1'b0;
      #70 done = 1'b1;
   end
   // drive on gate, else inverse of last
   wire logic drv = done && !pins_i.gate_n && !pins_i.select_n && !w;
   assign q_o = drv ? mem[a] : ~lst;
   always @(negedge drv) lst = mem[a];
   always @(posedge pins_i.select_n or posedge pins_i.wstrobe_n) begin
      if (w) mem[a] = bus_i;
      w = 1'b0;
   end
endmodule : bnvm_mem_model
`default_nettype wire

// *** bench/bnvm_ctrl_assertions.sv ***
/* Pin timing checks for the controller.
 Assumes one clock domain, bound by port names. */
`timescale 1ns/100ps
`default_nettype none
module bnvm_ctrl_assertions (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic supply_ok_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic byte_lines_oe_n_o,
   input wire bnvm_pkg::bnvm_pins_t pins_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // ====
   // Strobes, location and ready
   a_high_min: assert property ($rose(pins_o.select_n) |->
      pins_o.select_n[*8]) else $error("precharge short");
   a_low_min: assert property ($fell(pins_o.select_n) |->
      !pins_o.select_n[*8] ##1 !pins_o.select_n)
      else $error("select low short");
   a_low_max: assert property ($fell(pins_o.select_n) |->
      ##[1:250] pins_o.select_n) else $error("select low long");
   a_fresh_edge: assert property (rsp_valid_o |->
      $rose(pins_o.select_n)) else $error("no select edge");
   a_supply_hold: assert property (!supply_ok_i[*4] |->
      !req_ready_o) else $error("ready on bad supply");
   a_write_start: assert property ($fell(pins_o.wstrobe_n) |->
      $fell(pins_o.select_n) && !byte_lines_oe_n_o) else $error("wr start");
   a_write_body: assert property (!pins_o.wstrobe_n |->
      !pins_o.select_n && pins_o.gate_n) else $error("wr body");
   a_loc_steady: assert property (!pins_o.select_n &&
      $past(!pins_o.select_n) |-> $stable(pins_o.location_lines))
      else $error("location moved");
   c_write: cover property ($fell(pins_o.wstrobe_n));
   c_read: cover property ($fell(pins_o.gate_n));
   c_supply: cover property (!supply_ok_i ##1 supply_ok_i);
endmodule : bnvm_ctrl_assertions
bind bnvm_ctrl bnvm_ctrl_assertions i_chk (.clk_i(clk_i), .srst_i(srst_i),
   .supply_ok_i(supply_ok_i), .req_ready_o(req_ready_o),
   .rsp_valid_o(rsp_valid_o), .byte_lines_oe_n_o(byte_lines_oe_n_o),
   .pins_o(pins_o));
`default_nettype wire

// *** bench/tb_bytewide_nv_memory_read_port.sv ***
/* Bench for the controller against a behavioural memory.
 Assumes design, model and checker compile together. */
`timescale 1ns/100ps
`default_nettype none
module tb_bytewide_nv_memory_read_port;
   logic clk = 1'b0, srst_i = 1'b1, ok = 1'b1, vld = 1'b0, ce = 1'b1;
   logic rdy, rv, oen;
   logic [7:0] rd, bo, mq;
   bnvm_pkg::bnvm_req_t req = '0;
   bnvm_pkg::bnvm_pins_t pins;
   int error_cnt = 0, num_checks = 0;
   wire logic [7:0] bus = !oen ? bo : mq;
   initial forever #4 clk = ~clk;
   bnvm_ctrl i_dut (.clk_i(clk), .srst_i(srst_i), .ce_i(ce),
      .supply_ok_i(ok), .req_valid_i(vld), .req_i(req), .req_ready_o(rdy),
      .rsp_valid_o(rv), .rsp_data_o(rd), .pins_o(pins), .byte_lines_i(bus),
      .byte_lines_o(bo), .byte_lines_oe_n_o(oen));
   bnvm_mem_model i_mem (.pins_i(pins), .bus_i(bus), .q_o(mq));
   // ====
   // Shared tasks
   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // Request held until an edge that sees ready high
   task acc(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req = {w, a, d};
      vld = 1'b1;
      while (rdy !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      // Ready never seen: skip the response wait and fail
      if (rdy !== 1'b1) n = 120;
      @(negedge clk);
      vld = 1'b0;
      while (rv !== 1'b1 && n < 120) begin
         @(negedge clk);
         n++;
      end
      if (rv !== 1'b1) begin
         error_cnt++;
         conclude;
      end
   endtask : acc
   // ====
   // Scenarios
   task t_reset;
      chk({pins.select_n, pins.wstrobe_n, pins.gate_n, oen, rdy, rv},
         8'h3C);
      srst_i = 1'b0;
      $display("reset test done");
   endtask : t_reset
   task t_rw;
      logic [14:0] ad [3] = '{15'h0000, 15'h7FFF, 15'h1234};
      logic [7:0] dt [3] = '{8'h5A, 8'hC3, 8'h01};
      for (int i = 0; i < 3; i++) acc(1'b1, ad[i], dt[i]);
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, ad[i], 8'h00);
         chk(rd, dt[i]);
      end
      $display("write read test done");
   endtask : t_rw
   // Clock enable low must freeze ready and block any take
   task t_freeze;
      repeat (12) @(negedge clk);
      ce = 1'b0;
      req = {1'b0, 15'h1234, 8'h00};
      vld = 1'b1;
      repeat (10) begin
         @(negedge clk);
         chk({pins.select_n, rdy}, 8'h03);
      end
      ce = 1'b1;
      acc(1'b0, 15'h1234, 8'h00);
      chk(rd, 8'h01);
      $display("freeze test done");
   endtask : t_freeze
   task t_supply;
      ok = 1'b0;
      repeat (6) @(negedge clk);
      req = {1'b0, 15'h7FFF, 8'h00};
      vld = 1'b1;
      repeat (20) begin
         @(negedge clk);
         chk({pins.select_n, rdy}, 8'h02);
      end
      ok = 1'b1;
      acc(1'b0, 15'h7FFF, 8'h00);
      chk(rd, 8'hC3);
      $display("supply test done");
   endtask : t_supply
   initial begin
      repeat (5) @(negedge clk);
      t_reset;
      t_rw;
      t_freeze;
      t_supply;
      conclude;
   end
endmodule : tb_bytewide_nv_memory_read_port
`default_nettype wire
